// >>> hdl/hbp_pkg.sv
/*
 * constants, types and state layout of the host bus port.
 * assumes a 25 mhz system clock; timing figures are held in ns and
 * turned into whole clock cycles here.
 */
package hbp_pkg;
   localparam int CLK_NS          = 40;
   localparam int HOLD_MAX_NS     = 4 * CLK_NS + 2;
   localparam int HOLD_MAX_CYC    = (HOLD_MAX_NS / CLK_NS) < 1 ? 1 : HOLD_MAX_NS / CLK_NS;
   localparam int ACK_HIGH_MAX_NS = CLK_NS - 15;
   localparam int ACK_HIGH_CYC    = (ACK_HIGH_MAX_NS / CLK_NS) < 1 ? 1
                                    : ACK_HIGH_MAX_NS / CLK_NS;
   localparam int ADDR_W          = 16;
   localparam int DATA_W          = 8;
   localparam int SYNC_W          = ADDR_W + DATA_W + 4;

   typedef enum logic [1:0] {
      MODE_WAIT   = 2'h0,
      MODE_NOWAIT = 2'h1,
      MODE_68K    = 2'h2
   } hbp_mode_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_LATCH = 5'h02,
      ST_DONE  = 5'h04,
      ST_ACKHI = 5'h08,
      ST_START = 5'h10
   } hbp_state_t;

   typedef struct packed {
      logic              cs_n;
      logic              rd_n;
      logic              wr_n;
      logic              as_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hbp_pins_t;

   localparam hbp_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, as_n: 1'b1,
                                       addr: 16'h0000, data: 8'h00};

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hbp_acc_t;

   typedef struct packed {
      hbp_state_t        st;
      logic              mode_ok;
      hbp_mode_t         mode;
      logic              sel_prev;
      logic              is_wr;
      hbp_acc_t          acc;
      logic [DATA_W-1:0] rdata;
      logic              data_oe;
      logic              wait_n;
      logic              wait_oe;
      logic              ack_n;
      logic              ack_oe;
   } hbp_regs_t;
endpackage

// >>> hdl/hbp_sync.sv
/*
 * two-flop synchroniser for a group of pins.
 * assumes the group is sampled by the system clock only.
 */
`timescale 1ns/1ps
module hbp_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);
   logic [W-1:0] meta;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// >>> hdl/hbp_host_port.sv
/*
 * host bus port: generic bus with or without hold-off, or 68k-style bus
 * with address strobe and acknowledge. turns host strobes into single
 * cycle internal accesses.
 * assumes an internal register file that answers a read in the same
 * cycle as acc.rd, and pins that come from outside the clock domain.
 */
`timescale 1ns/1ps
module hbp_host_port
   import hbp_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire hbp_pkg::hbp_mode_t        bus_mode,
   input  wire logic                      direct_if,
   input  wire logic                      power_save,
   input  wire logic                      cs_n,
   input  wire logic                      rd_n,
   input  wire logic                      wr_n,
   input  wire logic                      addr_strobe_n,
   input  wire logic [hbp_pkg::ADDR_W-1:0] host_addr,
   input  wire logic [hbp_pkg::DATA_W-1:0] host_data_in,
   output logic      [hbp_pkg::DATA_W-1:0] host_data_out,
   output logic                           host_data_oe,
   output logic                           wait_n_out,
   output logic                           wait_n_oe,
   output logic                           transfer_ack_n_out,
   output logic                           transfer_ack_n_oe,
   output hbp_pkg::hbp_acc_t              acc,
   input  wire logic [hbp_pkg::DATA_W-1:0] acc_rdata
);
   import hbp_pkg::*;

   hbp_pins_t pins;
   hbp_pins_t pins_s;
   hbp_regs_t r;
   hbp_regs_t next_r;
   logic      sel;
   logic      is_68k;

   assign pins = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, as_n: addr_strobe_n,
                   addr: host_addr, data: host_data_in};

   hbp_sync #(
      .W       (SYNC_W),
      .RST_VAL (PINS_IDLE)
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     (pins),
      .q     (pins_s)
   );

   assign is_68k = (r.mode == MODE_68K);
   // access window: strobes qualified by chip select
   assign sel = r.mode_ok && !pins_s.cs_n &&
                (is_68k ? !pins_s.as_n : (!pins_s.rd_n || !pins_s.wr_n));

   always_comb begin
      next_r          = r;
      next_r.sel_prev = sel;
      next_r.acc.rd   = 1'b0;
      next_r.acc.wr   = 1'b0;
      unique case (r.st)
         ST_START: begin
            next_r.mode    = bus_mode;
            next_r.mode_ok = 1'b1;
            next_r.st      = ST_IDLE;
         end
         ST_IDLE: begin
            if (sel && !r.sel_prev) begin
               next_r.acc.addr = pins_s.addr;
               next_r.is_wr    = !pins_s.wr_n;
               next_r.acc.rd   = pins_s.wr_n;
               if (r.mode == MODE_WAIT) begin
                  next_r.wait_n  = 1'b0;
                  next_r.wait_oe = 1'b1;
               end
               if (is_68k) begin
                  next_r.ack_n  = 1'b1;
                  next_r.ack_oe = 1'b1;
               end
               next_r.st = ST_LATCH;
            end
         end
         ST_LATCH: begin
            if (!r.is_wr) begin
               next_r.rdata   = acc_rdata;
               next_r.data_oe = 1'b1;
            end else if (is_68k) begin
               next_r.acc.wdata = pins_s.data;
               next_r.acc.wr    = 1'b1;
            end
            next_r.wait_n = 1'b1;
            if (is_68k) begin
               next_r.ack_n = 1'b0;
            end
            next_r.st     = ST_DONE;
         end
         ST_DONE: begin
            if (r.is_wr && !is_68k) begin
               next_r.acc.wdata = pins_s.data;
            end
            if (!sel) begin
               next_r.data_oe = 1'b0;
               next_r.wait_oe = 1'b0;
               next_r.acc.wr  = r.is_wr && !is_68k;
               if (is_68k && !(direct_if && power_save)) begin
                  next_r.ack_n = 1'b1;
                  next_r.st    = ST_ACKHI;
               end else begin
                  next_r.ack_n  = 1'b1;
                  next_r.ack_oe = 1'b0;
                  next_r.st     = ST_IDLE;
               end
            end
         end
         ST_ACKHI: begin
            next_r.ack_oe = 1'b0;
            next_r.st     = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r.st       <= ST_START;
         r.mode_ok  <= 1'b0;
         r.mode     <= MODE_WAIT;
         r.sel_prev <= 1'b1;
         r.is_wr    <= 1'b0;
         r.acc      <= '0;
         r.rdata    <= 8'h00;
         r.data_oe  <= 1'b0;
         r.wait_n   <= 1'b1;
         r.wait_oe  <= 1'b0;
         r.ack_n    <= 1'b1;
         r.ack_oe   <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign host_data_out      = r.rdata;
   assign host_data_oe       = r.data_oe;
   assign wait_n_out         = r.wait_n;
   assign wait_n_oe          = r.wait_oe;
   assign transfer_ack_n_out = r.ack_n;
   assign transfer_ack_n_oe  = r.ack_oe;
   assign acc                = r.acc;
endmodule

// >>> tb/hbp_port_sva.sv
/* pin checker for hbp_host_port; assumes one bind per instance */
`timescale 1ns/1ps
module hbp_port_sva
   import hbp_pkg::*;
(
   input wire logic               clock,
   input wire logic               rst,
   input wire hbp_pkg::hbp_mode_t bus_mode,
   input wire logic               direct_if,
   input wire logic               power_save,
   input wire logic               cs_n,
   input wire logic               rd_n,
   input wire logic               wr_n,
   input wire logic               addr_strobe_n,
   input wire logic               host_data_oe,
   input wire logic               wait_n_out,
   input wire logic               wait_n_oe,
   input wire logic               transfer_ack_n_out,
   input wire logic               transfer_ack_n_oe,
   input wire hbp_pkg::hbp_acc_t  acc
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_wait_low: assert property ($rose(wait_n_oe) |-> !wait_n_out)
      else $error("hold-off not low");
   chk_wait_short: assert property (wait_n_oe && !wait_n_out |=> wait_n_out)
      else $error("hold-off too long");
   chk_rd_data: assert property (acc.rd |-> ##[1:2] host_data_oe)
      else $error("read data late");
   chk_wait_float: assert property ($rose(rd_n && wr_n) |-> ##[0:4] !wait_n_oe)
      else $error("hold-off not floated");
   chk_ack_drive: assert property (bus_mode == MODE_68K && !cs_n && $fell(addr_strobe_n)
      |-> ##[1:4] transfer_ack_n_oe)
      else $error("ack not driven");
   chk_ack_low: assert property ($rose(transfer_ack_n_oe)
      |-> transfer_ack_n_out ##1 !transfer_ack_n_out)
      else $error("ack not low");
   chk_ack_data: assert property ($fell(transfer_ack_n_out) && wr_n |-> ##[0:1] host_data_oe)
      else $error("68k data late");
   chk_ack_float: assert property (direct_if && power_save && $rose(addr_strobe_n)
      |-> ##[0:4] !transfer_ack_n_oe)
      else $error("ack not floated");
   chk_ack_high: assert property (!(direct_if && power_save) && transfer_ack_n_oe
      && $rose(addr_strobe_n) |-> ##[1:4] (transfer_ack_n_out && transfer_ack_n_oe))
      else $error("ack not high");
   chk_ack_release: assert property (transfer_ack_n_oe && $rose(transfer_ack_n_out)
      |=> !transfer_ack_n_oe)
      else $error("ack high too long");
   chk_mode_wait: assert property (bus_mode != MODE_WAIT |-> !wait_n_oe)
      else $error("hold-off in wrong mode");
   chk_mode_ack: assert property (bus_mode != MODE_68K |-> !transfer_ack_n_oe)
      else $error("ack in wrong mode");
endmodule
bind hbp_host_port hbp_port_sva i_hbp_port_sva (.clock, .rst, .bus_mode, .direct_if,
   .power_save, .cs_n, .rd_n, .wr_n, .addr_strobe_n, .host_data_oe, .wait_n_out,
   .wait_n_oe, .transfer_ack_n_out, .transfer_ack_n_oe, .acc);

// >>> tb/hbp_host_model.sv
/* host processor model; drives pins at falling clock edges */
`timescale 1ns/1ps
module hbp_host_model
   import hbp_pkg::*;
(
   input wire logic [hbp_pkg::DATA_W-1:0] dq,
   input wire logic                       clock,
   input wire logic                       ack_n,
   output hbp_pkg::hbp_pins_t             pins
);
   initial pins = PINS_IDLE;
   task automatic access(input logic m68, input logic w, input logic [15:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(negedge clock);
      pins.cs_n = 1'b0;
      pins.addr = a;
      pins.data = d;
      if (m68) begin
         pins.wr_n = !w;
         pins.as_n = 1'b0;
      end else if (w) pins.wr_n = 1'b0;
      else pins.rd_n = 1'b0;
      repeat (6) @(negedge clock);
      while (m68 && ack_n !== 1'b0 && n < 20) begin
         @(negedge clock);
         n++;
      end
      q = dq;
      pins.rd_n = 1'b1;
      pins.wr_n = 1'b1;
      pins.as_n = 1'b1;
      @(negedge clock);
      pins.cs_n = 1'b1;
      pins.data = ~d;
      pins.addr = ~a;
      repeat (10) @(negedge clock);
   endtask
endmodule

// >>> tb/hbp_host_port_tb.sv
/* bench for hbp_host_port; host model and a register file stub */
`timescale 1ns/1ps
module hbp_host_port_tb;
   import hbp_pkg::*;
   logic       clock = 1'b0, rst = 1'b1, direct_if = 1'b0, power_save = 1'b0;
   logic       saw_wait, oe, w_n, w_oe, k_n, k_oe, ack_lo, ack_rehi;
   logic [7:0] dout, q;
   hbp_mode_t  bus_mode = MODE_WAIT;
   hbp_pins_t  pins;
   hbp_acc_t   acc, last_wr;
   int         fail_count = 0, check_count = 0;
   initial forever #20 clock = ~clock;
   hbp_host_model i_hbp_host_model (.dq(dout), .clock(clock), .ack_n(k_n), .pins(pins));
   hbp_host_port i_hbp_host_port (.clock(clock), .rst(rst), .bus_mode(bus_mode),
      .direct_if(direct_if), .power_save(power_save), .cs_n(pins.cs_n), .rd_n(pins.rd_n),
      .wr_n(pins.wr_n), .addr_strobe_n(pins.as_n), .host_addr(pins.addr),
      .host_data_in(pins.data), .host_data_out(dout), .host_data_oe(oe), .wait_n_out(w_n),
      .wait_n_oe(w_oe), .transfer_ack_n_out(k_n), .transfer_ack_n_oe(k_oe), .acc(acc),
      .acc_rdata(acc.addr[7:0] ^ 8'h3c));
   always @(posedge clock) begin
      if (acc.wr) last_wr <= acc;
      if (w_oe && !w_n) saw_wait <= 1'b1;
      if (!k_oe) ack_lo <= 1'b0;
      else if (!k_n) ack_lo <= 1'b1;
      if (k_oe && k_n && ack_lo) ack_rehi <= 1'b1;
   end
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input hbp_mode_t m);
      rst = 1'b1;
      bus_mode = m;
      saw_wait = 1'b0;
      ack_rehi = 1'b0;
      last_wr = '0;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
   endtask
   task automatic t_rw(input hbp_mode_t m, input logic [15:0] a, input logic [7:0] d);
      do_reset(m);
      i_hbp_host_model.access(m == MODE_68K, 1'b1, a, d, q);
      check("wr addr", a, last_wr.addr);
      check("wr data", 16'(d), 16'(last_wr.wdata));
      i_hbp_host_model.access(m == MODE_68K, 1'b0, a, 8'h00, q);
      check("rd data", 16'(a[7:0] ^ 8'h3c), 16'(q));
      check("wait seen", 16'(m == MODE_WAIT), 16'(saw_wait));
      check("ack high", 16'(m == MODE_68K), 16'(ack_rehi));
   endtask
   task automatic t_ack_float;
      do_reset(MODE_68K);
      direct_if = 1'b1;
      power_save = 1'b1;
      i_hbp_host_model.access(1'b1, 1'b0, 16'h8000, 8'h00, q);
      check("ack oe", 16'h0000, 16'(k_oe));
      check("float rd", 16'h003c, 16'(q));
      i_hbp_host_model.access(1'b1, 1'b0, 16'h80c3, 8'h00, q);
      check("float rd", 16'h00ff, 16'(q));
      check("ack rehigh", 16'h0000, 16'(ack_rehi));
      direct_if = 1'b0;
      power_save = 1'b0;
   endtask
   initial begin
      t_rw(MODE_WAIT, 16'ha5c3, 8'h96);
      t_rw(MODE_NOWAIT, 16'hffff, 8'h00);
      t_rw(MODE_68K, 16'h0001, 8'hff);
      t_ack_float;
      wrap_up;
   end
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
endmodule
